// ---- pfm_regs.vh ----
// register indices, field positions and reset values of the port function mux
// assumes the includer uses these names only as constants
`ifndef PFM_REGS_VH
`define PFM_REGS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define PFM_IDX_PULLUP      8'h0c
`define PFM_IDX_RDRIVE      8'h0d
`define PFM_IDX_J_PULL_DIR  8'h2d
`define PFM_IDX_J_PULL_EN   8'h2e
`define PFM_IDX_DATA_BASE   8'h40
`define PFM_IDX_DDR_BASE    8'h50
`define PFM_IDX_MODE_CTL    8'h60
`define PFM_IDX_KW_EN_D     8'h61
`define PFM_IDX_KW_EN_H     8'h62
`define PFM_IDX_KW_EN_J     8'h63
`define PFM_IDX_STATE_BASE  8'h70
`define PFM_IDX_LSB         2
`define PFM_IDX_MSB         9

// ****************************************
// ports, in order of the flat pin vectors
// ****************************************
`define PFM_NUM_PORTS       9
`define PFM_PIN_BITS        72
`define PFM_PORT_A          0
`define PFM_PORT_B          1
`define PFM_PORT_C          2
`define PFM_PORT_D          3
`define PFM_PORT_E          4
`define PFM_PORT_H          5
`define PFM_PORT_J          6
`define PFM_PORT_S          7
`define PFM_PORT_T          8

// ****************************************
// fields
// ****************************************
`define PFM_MODE_EXPANDED   0
`define PFM_MODE_WIDE       1
`define PFM_MODE_QTRACK     2
`define PFM_E_IRQ_ZERO      0
`define PFM_E_IRQ_ONE       1
`define PFM_E_RW            2
`define PFM_E_STROBE        3
`define PFM_E_MODE_A        5
`define PFM_E_MODE_B        6
`define PFM_S_SLAVE_SEL     7

// ****************************************
// reset values and bus answers
// ****************************************
`define PFM_RST_PULLUP      8'hff
`define PFM_RST_RDRIVE      8'h00
`define PFM_RST_J_PULL_DIR  8'h00
`define PFM_RST_J_PULL_EN   8'h00
`define PFM_RST_MODE_CTL    8'h00
`define PFM_RST_BYTE        8'h00
`define PFM_ALL_ONES        8'hff
`define PFM_RESP_OKAY       2'h0
`define PFM_RESP_SLVERR     2'h2

`endif

// ---- pfm_sync.v ----
// two-flop synchroniser for a vector of pin inputs
// assumes pins change asynchronously to clk_in; freezes while en_in is low
`timescale 1ns/1ns
module pfm_sync #(
  parameter WIDTH = 72
) (
  // clock and control
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             en_in,
  // data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // stage_one feeds only sync_out, never any logic
  always @(posedge clk_in) begin
    if (rst_in) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else if (en_in) begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// ---- pfm_axil.v ----
// axi4-lite slave front end: one write and one read under way at a time
// assumes the register file answers rd_data_in and hit flags combinationally
`timescale 1ns/1ns
`include "pfm_regs.vh"
module pfm_axil (
  // clock and control
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       en_in,
  // write address and data
  input  wire [11:0] awaddr_in,
  input  wire       awvalid_in,
  output reg        awready_out,
  input  wire [31:0] wdata_in,
  input  wire [3:0] wstrb_in,
  input  wire       wvalid_in,
  output reg        wready_out,
  output reg  [1:0] bresp_out,
  output reg        bvalid_out,
  input  wire       bready_in,
  // read
  input  wire [11:0] araddr_in,
  input  wire       arvalid_in,
  output reg        arready_out,
  output reg  [31:0] rdata_out,
  output reg  [1:0] rresp_out,
  output reg        rvalid_out,
  input  wire       rready_in,
  // register file side
  output wire       wr_en_out,
  output reg  [7:0] wr_idx_out,
  output reg  [7:0] wr_data_out,
  output reg        wr_lane_out,
  input  wire       wr_hit_in,
  output reg  [7:0] rd_idx_out,
  input  wire [7:0] rd_data_in,
  input  wire       rd_hit_in
);

  reg aw_full;
  reg w_full;
  reg rd_pend;

  // commit only when no response is waiting, so responses never stack
  assign wr_en_out = en_in & aw_full & w_full & ~bvalid_out;

  // ****************************************
  // write channel
  // ****************************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      aw_full     <= 1'b0;
      w_full      <= 1'b0;
      awready_out <= 1'b0;
      wready_out  <= 1'b0;
      bvalid_out  <= 1'b0;
      bresp_out   <= `PFM_RESP_OKAY;
      wr_idx_out  <= `PFM_RST_BYTE;
      wr_data_out <= `PFM_RST_BYTE;
      wr_lane_out <= 1'b0;
    end else if (en_in) begin
      if (awvalid_in & awready_out) begin
        aw_full     <= 1'b1;
        awready_out <= 1'b0;
        wr_idx_out  <= awaddr_in[`PFM_IDX_MSB:`PFM_IDX_LSB];
      end else if (!aw_full) begin
        awready_out <= 1'b1;
      end
      if (wvalid_in & wready_out) begin
        w_full      <= 1'b1;
        wready_out  <= 1'b0;
        wr_data_out <= wdata_in[7:0];
        wr_lane_out <= wstrb_in[0];
      end else if (!w_full) begin
        wready_out <= 1'b1;
      end
      if (wr_en_out) begin
        aw_full    <= 1'b0;
        w_full     <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out  <= wr_hit_in ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
      end else if (bvalid_out & bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      arready_out <= 1'b0;
      rd_pend     <= 1'b0;
      rd_idx_out  <= `PFM_RST_BYTE;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h0000_0000;
      rresp_out   <= `PFM_RESP_OKAY;
    end else if (en_in) begin
      if (arvalid_in & arready_out) begin
        arready_out <= 1'b0;
        rd_pend     <= 1'b1;
        rd_idx_out  <= araddr_in[`PFM_IDX_MSB:`PFM_IDX_LSB];
      end else if (rd_pend) begin
        rd_pend    <= 1'b0;
        rvalid_out <= 1'b1;
        rdata_out  <= {24'h00_0000, rd_hit_in ? rd_data_in : `PFM_RST_BYTE};
        rresp_out  <= rd_hit_in ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
      end else if (rvalid_out & rready_in) begin
        rvalid_out  <= 1'b0;
        arready_out <= 1'b1;
      end else if (!rvalid_out) begin
        arready_out <= 1'b1;
      end
    end
  end

endmodule

// ---- pfm_top.v ----
// port function and pull mux: gives each port pin to general i/o or its alternate role
// assumes pins are synchronised here; bus, spi and timer inputs share REF_CLK_IN
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "pfm_regs.vh"
module pfm_top (
  // clock, reset, enable
  input  wire        REF_CLK_IN,
  input  wire        SYS_RST_IN,
  input  wire        CLK_EN_IN,
  // axi4-lite register bus
  input  wire [11:0] S_AXI_AWADDR_IN,
  input  wire        S_AXI_AWVALID_IN,
  output wire        S_AXI_AWREADY_OUT,
  input  wire [31:0] S_AXI_WDATA_IN,
  input  wire [3:0]  S_AXI_WSTRB_IN,
  input  wire        S_AXI_WVALID_IN,
  output wire        S_AXI_WREADY_OUT,
  output wire [1:0]  S_AXI_BRESP_OUT,
  output wire        S_AXI_BVALID_OUT,
  input  wire        S_AXI_BREADY_IN,
  input  wire [11:0] S_AXI_ARADDR_IN,
  input  wire        S_AXI_ARVALID_IN,
  output wire        S_AXI_ARREADY_OUT,
  output wire [31:0] S_AXI_RDATA_OUT,
  output wire [1:0]  S_AXI_RRESP_OUT,
  output wire        S_AXI_RVALID_OUT,
  input  wire        S_AXI_RREADY_IN,
  // external bus request from the core
  input  wire [15:0] EXT_ADDR_IN,
  input  wire [15:0] EXT_WDATA_IN,
  input  wire        EXT_WRITE_IN,
  input  wire        EIGHT_BIT_ACCESS_SIZE_IN,
  input  wire        NARROW_UPPER_PHASE_IN,
  output reg  [15:0] EXT_RDATA_OUT,
  // peripheral alternate functions
  input  wire [1:0]  QUEUE_TRACK_IN,
  input  wire        SPI_MASTER_IN,
  input  wire        SPI_SLAVE_SEL_IN,
  output reg         SPI_SLAVE_SEL_OUT,
  input  wire [7:0]  TIMER_CHANNEL_OUT_EN_IN,
  input  wire [7:0]  TIMER_CHANNEL_VALUE_IN,
  output reg  [7:0]  TIMER_CHANNEL_PINS_OUT,
  output reg  [23:0] KEY_WAKE_REQ_OUT,
  // pins, all nine ports packed a,b,c,d,e,h,j,s,t from bit 0 upward
  input  wire [71:0] PORT_PIN_IN,
  output reg  [71:0] PORT_PIN_OUT,
  output reg  [71:0] PORT_PIN_OE_OUT,
  // pull and drive controls
  output reg  [7:0]  PORT_PULLUP_ENABLE_OUT,
  output reg  [7:0]  PORT_REDUCED_DRIVE_OUT,
  output reg  [7:0]  PORTJ_PULLUP_OUT,
  output reg  [7:0]  PORTJ_PULLDOWN_OUT
);

  // ****************************************
  // register file storage
  // ****************************************
  reg  [7:0] port_data [0:`PFM_NUM_PORTS-1];
  reg  [7:0] port_dir  [0:`PFM_NUM_PORTS-1];
  reg  [7:0] port_pullup_enable;
  reg  [7:0] port_reduced_drive;
  reg  [7:0] portj_pull_direction_select;
  reg  [7:0] portj_pull_enable;
  reg  [7:0] mode_ctl;
  reg  [7:0] kw_en_d;
  reg  [7:0] kw_en_h;
  reg  [7:0] kw_en_j;
  reg  [71:0] pin_prev;
  reg  [7:0] rd_data;
  reg  [71:0] next_pin_out;
  reg  [71:0] next_pin_oe;
  reg        next_strobe;
  integer    i, j, m;

  wire [71:0] pin_sync;
  wire        wr_en;
  wire [7:0]  wr_idx;
  wire [7:0]  wr_data;
  wire        wr_lane;
  wire [7:0]  rd_idx;
  wire        expanded = mode_ctl[`PFM_MODE_EXPANDED];
  wire        wide     = mode_ctl[`PFM_MODE_WIDE];

  // true when idx falls in a per-port block starting at base
  function in_block;
    input [7:0] idx;
    input [7:0] base;
    begin
      in_block = (idx >= base) && (idx < base + `PFM_NUM_PORTS);
    end
  endfunction

  // true for any mapped register index
  function reg_hit;
    input [7:0] idx;
    begin
      reg_hit = in_block(idx, `PFM_IDX_DATA_BASE) || in_block(idx, `PFM_IDX_DDR_BASE)
             || in_block(idx, `PFM_IDX_STATE_BASE)
             || idx == `PFM_IDX_PULLUP || idx == `PFM_IDX_RDRIVE
             || idx == `PFM_IDX_J_PULL_DIR || idx == `PFM_IDX_J_PULL_EN
             || idx == `PFM_IDX_MODE_CTL || idx == `PFM_IDX_KW_EN_D
             || idx == `PFM_IDX_KW_EN_H || idx == `PFM_IDX_KW_EN_J;
    end
  endfunction

  // ****************************************
  // submodules
  // ****************************************
  pfm_sync #(
    .WIDTH (`PFM_PIN_BITS)
  ) u_sync (
    .clk_in   (REF_CLK_IN),
    .rst_in   (SYS_RST_IN),
    .en_in    (CLK_EN_IN),
    .async_in (PORT_PIN_IN),
    .sync_out (pin_sync)
  );

  pfm_axil u_axil (
    .clk_in      (REF_CLK_IN),
    .rst_in      (SYS_RST_IN),
    .en_in       (CLK_EN_IN),
    .awaddr_in   (S_AXI_AWADDR_IN),
    .awvalid_in  (S_AXI_AWVALID_IN),
    .awready_out (S_AXI_AWREADY_OUT),
    .wdata_in    (S_AXI_WDATA_IN),
    .wstrb_in    (S_AXI_WSTRB_IN),
    .wvalid_in   (S_AXI_WVALID_IN),
    .wready_out  (S_AXI_WREADY_OUT),
    .bresp_out   (S_AXI_BRESP_OUT),
    .bvalid_out  (S_AXI_BVALID_OUT),
    .bready_in   (S_AXI_BREADY_IN),
    .araddr_in   (S_AXI_ARADDR_IN),
    .arvalid_in  (S_AXI_ARVALID_IN),
    .arready_out (S_AXI_ARREADY_OUT),
    .rdata_out   (S_AXI_RDATA_OUT),
    .rresp_out   (S_AXI_RRESP_OUT),
    .rvalid_out  (S_AXI_RVALID_OUT),
    .rready_in   (S_AXI_RREADY_IN),
    .wr_en_out   (wr_en),
    .wr_idx_out  (wr_idx),
    .wr_data_out (wr_data),
    .wr_lane_out (wr_lane),
    .wr_hit_in   (reg_hit(wr_idx)),
    .rd_idx_out  (rd_idx),
    .rd_data_in  (rd_data),
    .rd_hit_in   (reg_hit(rd_idx))
  );

  // ****************************************
  // register writes
  // ****************************************
  // a write to a mapped index with byte lane 0 off is answered okay but stores nothing
  always @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      for (i = 0; i < `PFM_NUM_PORTS; i = i + 1) begin
        port_data[i] <= `PFM_RST_BYTE;
        port_dir[i]  <= `PFM_RST_BYTE;
      end
      port_pullup_enable          <= `PFM_RST_PULLUP;
      port_reduced_drive          <= `PFM_RST_RDRIVE;
      portj_pull_direction_select <= `PFM_RST_J_PULL_DIR;
      portj_pull_enable           <= `PFM_RST_J_PULL_EN;
      mode_ctl                    <= `PFM_RST_MODE_CTL;
      kw_en_d                     <= `PFM_RST_BYTE;
      kw_en_h                     <= `PFM_RST_BYTE;
      kw_en_j                     <= `PFM_RST_BYTE;
    end else if (CLK_EN_IN && wr_en && wr_lane) begin
      for (i = 0; i < `PFM_NUM_PORTS; i = i + 1) begin
        if (wr_idx == `PFM_IDX_DATA_BASE + i) begin
          port_data[i] <= wr_data;
        end
        if (wr_idx == `PFM_IDX_DDR_BASE + i) begin
          port_dir[i] <= wr_data;
        end
      end
      case (wr_idx)
        `PFM_IDX_PULLUP:     port_pullup_enable <= wr_data;
        `PFM_IDX_RDRIVE:     port_reduced_drive <= wr_data;
        `PFM_IDX_J_PULL_DIR: portj_pull_direction_select <= wr_data;
        `PFM_IDX_J_PULL_EN:  portj_pull_enable <= wr_data;
        `PFM_IDX_MODE_CTL:   mode_ctl <= wr_data;
        `PFM_IDX_KW_EN_D:    kw_en_d <= wr_data;
        `PFM_IDX_KW_EN_H:    kw_en_h <= wr_data;
        `PFM_IDX_KW_EN_J:    kw_en_j <= wr_data;
        default:             mode_ctl <= mode_ctl;
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always @* begin
    rd_data = `PFM_RST_BYTE;
    for (j = 0; j < `PFM_NUM_PORTS; j = j + 1) begin
      if (rd_idx == `PFM_IDX_DATA_BASE + j) begin
        rd_data = port_data[j];
      end
      if (rd_idx == `PFM_IDX_DDR_BASE + j) begin
        rd_data = port_dir[j];
      end
      // live pin level, after synchronising
      if (rd_idx == `PFM_IDX_STATE_BASE + j) begin
        rd_data = pin_sync[j*8 +: 8];
      end
    end
    case (rd_idx)
      `PFM_IDX_PULLUP:     rd_data = port_pullup_enable;
      `PFM_IDX_RDRIVE:     rd_data = port_reduced_drive;
      `PFM_IDX_J_PULL_DIR: rd_data = portj_pull_direction_select;
      `PFM_IDX_J_PULL_EN:  rd_data = portj_pull_enable;
      `PFM_IDX_MODE_CTL:   rd_data = mode_ctl;
      `PFM_IDX_KW_EN_D:    rd_data = kw_en_d;
      `PFM_IDX_KW_EN_H:    rd_data = kw_en_h;
      `PFM_IDX_KW_EN_J:    rd_data = kw_en_j;
      default:             rd_data = rd_data;
    endcase
  end

  // ****************************************
  // pin function mux
  // ****************************************
  always @* begin
    // general i/o everywhere, then alternates override
    for (m = 0; m < `PFM_NUM_PORTS; m = m + 1) begin
      next_pin_out[m*8 +: 8] = port_data[m];
      next_pin_oe[m*8 +: 8]  = port_dir[m];
    end
    next_strobe = ~(EXT_ADDR_IN[0] ^ EIGHT_BIT_ACCESS_SIZE_IN);
    if (expanded) begin
      next_pin_out[`PFM_PORT_A*8 +: 8] = EXT_ADDR_IN[15:8];
      next_pin_oe[`PFM_PORT_A*8 +: 8]  = `PFM_ALL_ONES;
      next_pin_out[`PFM_PORT_B*8 +: 8] = EXT_ADDR_IN[7:0];
      next_pin_oe[`PFM_PORT_B*8 +: 8]  = `PFM_ALL_ONES;
      // data lines drive only during write cycles
      next_pin_oe[`PFM_PORT_C*8 +: 8] = {8{EXT_WRITE_IN}};
      if (wide) begin
        next_pin_out[`PFM_PORT_C*8 +: 8] = EXT_WDATA_IN[15:8];
        next_pin_out[`PFM_PORT_D*8 +: 8] = EXT_WDATA_IN[7:0];
        next_pin_oe[`PFM_PORT_D*8 +: 8]  = {8{EXT_WRITE_IN}};
      end else begin
        next_pin_out[`PFM_PORT_C*8 +: 8] = NARROW_UPPER_PHASE_IN ? EXT_WDATA_IN[15:8]
                                                                 : EXT_WDATA_IN[7:0];
      end
      next_pin_out[`PFM_PORT_E*8 + `PFM_E_RW]     = ~EXT_WRITE_IN;
      next_pin_oe[`PFM_PORT_E*8 + `PFM_E_RW]      = 1'b1;
      next_pin_out[`PFM_PORT_E*8 + `PFM_E_STROBE] = next_strobe;
      next_pin_oe[`PFM_PORT_E*8 + `PFM_E_STROBE]  = 1'b1;
    end
    if (mode_ctl[`PFM_MODE_QTRACK]) begin
      next_pin_out[`PFM_PORT_E*8 + `PFM_E_MODE_A] = QUEUE_TRACK_IN[0];
      next_pin_out[`PFM_PORT_E*8 + `PFM_E_MODE_B] = QUEUE_TRACK_IN[1];
      next_pin_oe[`PFM_PORT_E*8 + `PFM_E_MODE_A]  = 1'b1;
      next_pin_oe[`PFM_PORT_E*8 + `PFM_E_MODE_B]  = 1'b1;
    end
    // interrupt request lines never drive, whatever the direction bits say
    next_pin_oe[`PFM_PORT_E*8 + `PFM_E_IRQ_ZERO] = 1'b0;
    next_pin_oe[`PFM_PORT_E*8 + `PFM_E_IRQ_ONE]  = 1'b0;
    next_pin_out[`PFM_PORT_S*8 + `PFM_S_SLAVE_SEL] = SPI_SLAVE_SEL_IN;
    next_pin_oe[`PFM_PORT_S*8 + `PFM_S_SLAVE_SEL]  = SPI_MASTER_IN;
    for (m = 0; m < 8; m = m + 1) begin
      if (TIMER_CHANNEL_OUT_EN_IN[m]) begin
        next_pin_out[`PFM_PORT_T*8 + m] = TIMER_CHANNEL_VALUE_IN[m];
        next_pin_oe[`PFM_PORT_T*8 + m]  = 1'b1;
      end
    end
  end

  // ****************************************
  // output flops and key wakeup
  // ****************************************
  // one cycle of output latency keeps every pin glitch free
  always @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      PORT_PIN_OUT           <= 72'h0;
      PORT_PIN_OE_OUT        <= 72'h0;
      pin_prev               <= 72'h0;
      KEY_WAKE_REQ_OUT       <= 24'h00_0000;
      EXT_RDATA_OUT          <= 16'h0000;
      SPI_SLAVE_SEL_OUT      <= 1'b0;
      TIMER_CHANNEL_PINS_OUT <= `PFM_RST_BYTE;
      PORT_PULLUP_ENABLE_OUT <= `PFM_RST_PULLUP;
      PORT_REDUCED_DRIVE_OUT <= `PFM_RST_RDRIVE;
      PORTJ_PULLUP_OUT       <= `PFM_RST_BYTE;
      PORTJ_PULLDOWN_OUT     <= `PFM_RST_BYTE;
    end else if (CLK_EN_IN) begin
      PORT_PIN_OUT <= next_pin_out;
      PORT_PIN_OE_OUT <= next_pin_oe;
      pin_prev <= pin_sync;
      KEY_WAKE_REQ_OUT[7:0] <= kw_en_d & pin_prev[`PFM_PORT_D*8 +: 8]
                               & ~pin_sync[`PFM_PORT_D*8 +: 8];
      KEY_WAKE_REQ_OUT[15:8] <= kw_en_h & pin_prev[`PFM_PORT_H*8 +: 8]
                                & ~pin_sync[`PFM_PORT_H*8 +: 8];
      KEY_WAKE_REQ_OUT[23:16] <= kw_en_j & (pin_prev[`PFM_PORT_J*8 +: 8]
                                 ^ pin_sync[`PFM_PORT_J*8 +: 8]);
      // narrow mode: core picks the byte by its own phase
      EXT_RDATA_OUT <= {pin_sync[`PFM_PORT_C*8 +: 8],
                        wide ? pin_sync[`PFM_PORT_D*8 +: 8] : pin_sync[`PFM_PORT_C*8 +: 8]};
      SPI_SLAVE_SEL_OUT <= pin_sync[`PFM_PORT_S*8 + `PFM_S_SLAVE_SEL];
      TIMER_CHANNEL_PINS_OUT <= pin_sync[`PFM_PORT_T*8 +: 8];
      PORT_PULLUP_ENABLE_OUT <= port_pullup_enable;
      PORT_REDUCED_DRIVE_OUT <= port_reduced_drive;
      PORTJ_PULLUP_OUT <= portj_pull_enable & portj_pull_direction_select;
      PORTJ_PULLDOWN_OUT <= portj_pull_enable & ~portj_pull_direction_select;
    end
  end

endmodule

// ---- pfm_board.sv ----
// board model: memories and peripherals that sit on the port pins
// assumes the bench sets what the board drives on every pin the device releases
`timescale 1ns/1ns
module pfm_board (
  // device side
  input  wire logic [71:0] pin_out_in,
  input  wire logic [71:0] pin_oe_in,
  // board drive values
  input  wire logic [71:0] drv_in,
  output wire logic [71:0] pin_in_out
);
  // a driven pin shows the device value, a released one what the board puts there
  assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drv_in);
endmodule

// ---- pfm_top_sva.sv ----
// checker of the port function mux, bound to the top module
// assumes CLK_EN_IN stays high, so no flop is frozen
`timescale 1ns/1ns
module pfm_chk (
  // clock and reset
  input wire logic        REF_CLK_IN,
  input wire logic        SYS_RST_IN,
  // bus
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  // alternate functions
  input wire logic        SPI_MASTER_IN,
  input wire logic        SPI_SLAVE_SEL_IN,
  input wire logic [7:0]  TIMER_CHANNEL_OUT_EN_IN,
  input wire logic [7:0]  TIMER_CHANNEL_VALUE_IN,
  // pins and pulls
  input wire logic [71:0] PORT_PIN_OUT,
  input wire logic [71:0] PORT_PIN_OE_OUT,
  input wire logic [7:0]  PORT_PULLUP_ENABLE_OUT,
  input wire logic [7:0]  PORTJ_PULLUP_OUT,
  input wire logic [7:0]  PORTJ_PULLDOWN_OUT
);
  // ****************************************
  // assertions
  // ****************************************
  chk_pe_input_only: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    PORT_PIN_OE_OUT[33:32] == 2'h0) else $error("port e irq line driven");
  chk_j_pull_excl: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    (PORTJ_PULLUP_OUT & PORTJ_PULLDOWN_OUT) == 8'h00) else $error("pullup and pulldown both on");
  chk_reset_state: assert property (@(posedge REF_CLK_IN) SYS_RST_IN |=>
    PORT_PIN_OE_OUT == 72'h0 && PORT_PULLUP_ENABLE_OUT == 8'hff
    && (PORTJ_PULLUP_OUT | PORTJ_PULLDOWN_OUT) == 8'h00) else $error("bad reset state");
  chk_spi_master: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !$past(SYS_RST_IN) && $past(SPI_MASTER_IN) |-> PORT_PIN_OE_OUT[63]
    && PORT_PIN_OUT[63] == $past(SPI_SLAVE_SEL_IN)) else $error("slave select not driven");
  chk_spi_slave: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !$past(SYS_RST_IN) && !$past(SPI_MASTER_IN) |-> !PORT_PIN_OE_OUT[63])
    else $error("slave select driven in slave mode");
  chk_timer_owns: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !$past(SYS_RST_IN) |-> (PORT_PIN_OE_OUT[71:64] & $past(TIMER_CHANNEL_OUT_EN_IN))
    == $past(TIMER_CHANNEL_OUT_EN_IN) && ((PORT_PIN_OUT[71:64] ^ $past(TIMER_CHANNEL_VALUE_IN))
    & $past(TIMER_CHANNEL_OUT_EN_IN)) == 8'h00) else $error("timer pin not owned");
  chk_bresp_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write response dropped");
  chk_read_latency: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> !S_AXI_RVALID_OUT ##1 S_AXI_RVALID_OUT)
    else $error("read answer late or early");
endmodule

// ---- tb.sv ----
// self-checking bench of the port function mux over axi4-lite and the pins
// assumes a board model resolves every pin; checker bound below
`timescale 1ns/1ns
`include "pfm_regs.vh"
module tb;
  reg        REF_CLK_IN = 1'b0, SYS_RST_IN = 1'b1, CLK_EN_IN = 1'b1;
  reg [11:0] S_AXI_AWADDR_IN = 12'h0, S_AXI_ARADDR_IN = 12'h0;
  reg [31:0] S_AXI_WDATA_IN = 32'h0;
  reg [3:0]  S_AXI_WSTRB_IN = 4'hf;
  reg        S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0;
  reg        S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0, EXT_WRITE_IN = 0;
  reg        EIGHT_BIT_ACCESS_SIZE_IN = 0, NARROW_UPPER_PHASE_IN = 0;
  reg        SPI_MASTER_IN = 0, SPI_SLAVE_SEL_IN = 0;
  reg [15:0] EXT_ADDR_IN = 16'h0, EXT_WDATA_IN = 16'h0;
  reg [1:0]  QUEUE_TRACK_IN = 2'h0;
  reg [7:0]  TIMER_CHANNEL_OUT_EN_IN = 8'h00, TIMER_CHANNEL_VALUE_IN = 8'h00;
  reg [71:0] drv = {72{1'b1}};
  wire       S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT;
  wire       S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, SPI_SLAVE_SEL_OUT;
  wire [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
  wire [31:0] S_AXI_RDATA_OUT;
  wire [15:0] EXT_RDATA_OUT;
  wire [7:0] TIMER_CHANNEL_PINS_OUT, PORT_PULLUP_ENABLE_OUT, PORT_REDUCED_DRIVE_OUT;
  wire [7:0] PORTJ_PULLUP_OUT, PORTJ_PULLDOWN_OUT;
  wire [23:0] KEY_WAKE_REQ_OUT;
  wire [71:0] PORT_PIN_IN, PORT_PIN_OUT, PORT_PIN_OE_OUT;
  integer    error_cnt = 0, checks = 0, k, n;
  reg [1:0]  r;
  reg [31:0] d;
  reg        seen;
  pfm_top dut_u (.*);
  pfm_board brd_u (.pin_out_in(PORT_PIN_OUT), .pin_oe_in(PORT_PIN_OE_OUT), .drv_in(drv),
    .pin_in_out(PORT_PIN_IN));
  initial forever #20 REF_CLK_IN = ~REF_CLK_IN;
  // ****************************************
  // tasks
  // ****************************************
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [71:0] s, input [71:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge REF_CLK_IN);
  endtask
  // wait is bounded; a hang counts as a mismatch
  task step;
    begin
      @(posedge REF_CLK_IN);
      n = n + 1;
      if (n > 60) begin
        error_cnt = error_cnt + 1;
        stop_test;
      end
    end
  endtask
  task axi_wr(input [7:0] i, input [7:0] v, output [1:0] rs);
    begin
      @(posedge REF_CLK_IN);
      S_AXI_AWADDR_IN <= {2'h0, i, 2'h0};
      S_AXI_WDATA_IN <= {24'h0, v};
      S_AXI_AWVALID_IN <= 1'b1;
      S_AXI_WVALID_IN <= 1'b1;
      S_AXI_BREADY_IN <= 1'b1;
      n = 0;
      do begin
        step;
        if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'b0;
        if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'b0;
      end while (!S_AXI_BVALID_OUT);
      rs = S_AXI_BRESP_OUT;
      S_AXI_BREADY_IN <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] i, output [31:0] v, output [1:0] rs);
    begin
      @(posedge REF_CLK_IN);
      S_AXI_ARADDR_IN <= {2'h0, i, 2'h0};
      S_AXI_ARVALID_IN <= 1'b1;
      S_AXI_RREADY_IN <= 1'b1;
      n = 0;
      do begin
        step;
        if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'b0;
      end while (!S_AXI_RVALID_OUT);
      v = S_AXI_RDATA_OUT;
      rs = S_AXI_RRESP_OUT;
      S_AXI_RREADY_IN <= 1'b0;
    end
  endtask
  task wr(input [7:0] i, input [7:0] v);
    begin
      axi_wr(i, v, r);
      chk(r, `PFM_RESP_OKAY);
    end
  endtask
  task rdc(input [7:0] i, input [7:0] e);
    begin
      axi_rd(i, d, r);
      chk({r, d}, {`PFM_RESP_OKAY, 24'h0, e});
    end
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    cyc(10);
    SYS_RST_IN <= 1'b0;
    cyc(2);
    rdc(`PFM_IDX_PULLUP, 8'hff);
    rdc(`PFM_IDX_J_PULL_DIR, 8'h00);
    rdc(`PFM_IDX_J_PULL_EN, 8'h00);
    rdc(`PFM_IDX_RDRIVE, 8'h00);
    axi_wr(8'h3f, 8'h11, r);
    chk(r, `PFM_RESP_SLVERR);
    axi_rd(8'h3f, d, r);
    chk({r, d}, {`PFM_RESP_SLVERR, 32'h0});
    wr(`PFM_IDX_J_PULL_DIR, 8'ha5);
    wr(`PFM_IDX_J_PULL_EN, 8'h0f);
    wr(`PFM_IDX_RDRIVE, 8'h3c);
    wr(`PFM_IDX_PULLUP, 8'h3c);
    wr(`PFM_IDX_DATA_BASE, 8'h3c);
    wr(`PFM_IDX_DDR_BASE, 8'hff);
    wr(`PFM_IDX_DDR_BASE + 8'h04, 8'hff);
    cyc(2);
    chk({PORTJ_PULLUP_OUT, PORTJ_PULLDOWN_OUT}, 16'h050a);
    chk({PORT_PULLUP_ENABLE_OUT, PORT_REDUCED_DRIVE_OUT}, 16'h3c3c);
    chk({PORT_PIN_OE_OUT[7:0], PORT_PIN_OUT[7:0]}, 16'hff3c);
    chk(PORT_PIN_OE_OUT[33:32], 2'h0);
    // narrow expanded: address bus overrides the port a data register
    EXT_ADDR_IN <= 16'h1235;
    EXT_WDATA_IN <= 16'hbeef;
    EXT_WRITE_IN <= 1'b1;
    NARROW_UPPER_PHASE_IN <= 1'b1;
    wr(`PFM_IDX_MODE_CTL, 8'h01);
    cyc(2);
    chk(PORT_PIN_OUT[23:0], 24'hbe3512);
    chk(PORT_PIN_OE_OUT[31:0], 32'h00ffffff);
    NARROW_UPPER_PHASE_IN <= 1'b0;
    cyc(2);
    chk(PORT_PIN_OUT[23:16], 8'hef);
    for (k = 0; k < 4; k = k + 1) begin
      EXT_ADDR_IN <= {15'h0, k[0]};
      EIGHT_BIT_ACCESS_SIZE_IN <= k[1];
      cyc(2);
      chk(PORT_PIN_OUT[35], k[0] == k[1]);
    end
    wr(`PFM_IDX_MODE_CTL, 8'h03);
    cyc(2);
    chk({PORT_PIN_OE_OUT[31:16], PORT_PIN_OUT[31:16]}, 32'hffffefbe);
    EXT_WRITE_IN <= 1'b0;
    drv[31:16] <= 16'hc35a;
    cyc(5);
    chk({PORT_PIN_OE_OUT[31:16], EXT_RDATA_OUT}, 32'h00005ac3);
    QUEUE_TRACK_IN <= 2'h2;
    wr(`PFM_IDX_MODE_CTL, 8'h04);
    cyc(2);
    chk({PORT_PIN_OE_OUT[38:37], PORT_PIN_OUT[38:37]}, 4'he);
    QUEUE_TRACK_IN <= 2'h1;
    cyc(2);
    chk(PORT_PIN_OUT[38:37], 2'h1);
    wr(`PFM_IDX_DDR_BASE + 8'h04, 8'h00);
    wr(`PFM_IDX_MODE_CTL, 8'h00);
    cyc(2);
    chk(PORT_PIN_OE_OUT[38:37], 2'h0);
    // key wakeup: fall then rise on d, h and j
    drv[31:24] <= 8'hff;
    wr(`PFM_IDX_KW_EN_D, 8'hff);
    wr(`PFM_IDX_KW_EN_H, 8'hff);
    wr(`PFM_IDX_KW_EN_J, 8'hff);
    cyc(6);
    for (k = 0; k < 6; k = k + 1) begin
      drv[(k < 2) ? 24 : (k < 4) ? 40 : 48] <= k[0];
      seen = 1'b0;
      repeat (10) begin
        @(posedge REF_CLK_IN);
        if (KEY_WAKE_REQ_OUT[(k / 2) * 8] === 1'b1) seen = 1'b1;
      end
      chk(seen, !k[0] || k > 3);
    end
    SPI_MASTER_IN <= 1'b1;
    SPI_SLAVE_SEL_IN <= 1'b1;
    TIMER_CHANNEL_OUT_EN_IN <= 8'h0f;
    TIMER_CHANNEL_VALUE_IN <= 8'h05;
    cyc(5);
    chk({PORT_PIN_OE_OUT[63], SPI_SLAVE_SEL_OUT}, 2'h3);
    chk(TIMER_CHANNEL_PINS_OUT, 8'hf5);
    SPI_MASTER_IN <= 1'b0;
    drv[63] <= 1'b0;
    cyc(5);
    chk({PORT_PIN_OE_OUT[63], SPI_SLAVE_SEL_OUT}, 2'h0);
    stop_test;
  end
endmodule
bind pfm_top pfm_chk chk_u (.*);
